/* File: iowd_top.sv */
/*
   i/o watchdog with event flag register and combined interrupt.
   assumes a register port driven by the fieldbus side or a local host,
   all pins synchronous to clock, event_in pulses one cycle wide.
*/
// Summary of operation
// - A zero watchdog period disables the watchdog, any other value is the timeout in 25 MHz cycles.
// - With sticky_timeout clear, the next retrigger ends the watchdog action.
// - With sticky_timeout set, only rewriting the period clears an active timeout.
// - Rising edges of host_port_select_n or ctrl_port_select_n retrigger when config bit 1 or 2 is set.
// - With config bit 3 set, each fieldbus start of frame retriggers.
// - Config bit 4 picks whether the input condition retriggers on becoming false or true.
// - Config bit 7 shows timeout_active while a timeout is in effect.
// - On timeout each selected output line is driven to its safe level, others are untouched.
// - On timeout each affected line takes its output enable from the safe enable register.
// - With config bit 4 set, each selected input line retriggers when it reaches its programmed level; with it clear, when it leaves it.
// - peak_count holds the highest count reached and is zeroed by a period write.
// - Event flag bit 11 is set on timeout, bits 22:20 are reserved and read zero.
// - Reading the event flag register clears all its flags except those raised in the cycle of the read.
// - Flags gated by their enable bits are combined onto one interrupt output.
`timescale 1ns/1ps
`default_nettype none
`include "iowd_cfg.svh"

module iowd_top
   import iowd_pkg::*;
#(
   parameter int TICK_DIV = `IOWD_TICK_DIV
)
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [63:0] reg_wdata,
   output logic [63:0] reg_rdata,
   // retrigger sources
   input wire logic host_port_select_n,
   input wire logic ctrl_port_select_n,
   input wire logic frame_start,
   input wire logic [`IOWD_LINES-1:0] io_in,
   // normal output path and other event sources
   input wire logic [`IOWD_LINES-1:0] app_out,
   input wire logic [`IOWD_OE_W-1:0] app_oe,
   input wire logic [`IOWD_LINES-1:0] event_in,
   // pins and status
   output logic [`IOWD_LINES-1:0] io_out,
   output logic [`IOWD_OE_W-1:0] io_oe,
   output logic timeout_active,
   output logic combined_irq_out
);

   localparam logic [`IOWD_PRESC_W-1:0] TICK_LAST = `IOWD_PRESC_W'(TICK_DIV - 1);
   localparam logic [`IOWD_LINES-1:0] FLAG_RESERVED = `IOWD_FLAG_RESERVED;

   iowd_state_t st;
   iowd_state_t next_st;

   logic [`IOWD_SYNC_W-1:0] sy_level;
   logic [`IOWD_SYNC_W-1:0] sy_rise;
   logic [`IOWD_SYNC_W-1:0] sy_fall;
   logic [`IOWD_LINES-1:0] ovr_out;
   logic [`IOWD_OE_W-1:0] ovr_oe;

   // bit 26 host select, 25 ctrl select, 24 frame start, 23:0 inputs
   iowd_sync_edge u_sync
   (
      .clock(clock),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .raw({host_port_select_n, ctrl_port_select_n, frame_start, io_in}),
      .level(sy_level),
      .rise(sy_rise),
      .fall(sy_fall)
   );

   // override mux per line, from the registered active flag
   genvar gi;
   generate
      for (gi = 0; gi < `IOWD_LINES; gi++)
      begin : g_line
         assign ovr_out[gi] = (st.timeout_active && st.output_override_select[gi]) ?
                              st.output_safe_level[gi] : app_out[gi];
         assign ovr_oe[gi] = (st.timeout_active && st.output_override_select[gi]) ?
                             st.output_enable_safe_levels[gi] : app_oe[gi];
      end
   endgenerate
   // enable lines without a select bit are never overridden
   assign ovr_oe[`IOWD_OE_W-1:`IOWD_LINES] = app_oe[`IOWD_OE_W-1:`IOWD_LINES];

   always_comb
   begin
      logic [`IOWD_LINES-1:0] cond;
      logic [`IOWD_LINES-1:0] cond_edge;
      logic [`IOWD_LINES-1:0] flag_set;
      logic retrig;
      logic tick;
      logic timeout_evt;
      logic flags_read;
      cond = '0;
      cond_edge = '0;
      flag_set = '0;
      retrig = 1'b0;
      tick = 1'b0;
      timeout_evt = 1'b0;
      flags_read = 1'b0;
      next_st = st;

      // input condition per line and its chosen edge
      cond = ~(sy_level[`IOWD_LINES-1:0] ^ st.input_retrigger_level);
      if (st.in_edge)
      begin
         cond_edge = cond & ~st.cond_prev;
      end
      else
      begin
         cond_edge = ~cond & st.cond_prev;
      end
      next_st.cond_prev = cond;

      retrig = (st.host_en && sy_rise[26]) || (st.ctrl_en && sy_rise[25])
               || (st.sof_en && sy_rise[24])
               || (|(cond_edge & st.input_retrigger_select));

      // 25 MHz count tick from the system clock
      tick = (st.presc == TICK_LAST);
      if (tick)
      begin
         next_st.presc = '0;
      end
      else
      begin
         next_st.presc = st.presc + `IOWD_PRESC_W'(1);
      end

      if (st.watchdog_period == 32'h00000000)
      begin
         next_st.count = '0;
         next_st.timeout_active = 1'b0;
      end
      else if (retrig)
      begin
         next_st.count = '0;
         if (!st.sticky_timeout)
         begin
            next_st.timeout_active = 1'b0;
         end
         // sticky mode keeps the timeout until the period is rewritten
      end
      else if (tick && st.count != st.watchdog_period)
      begin
         next_st.count = st.count + 32'h00000001;
         if (st.count + 32'h00000001 == st.watchdog_period && !st.timeout_active)
         begin
            next_st.timeout_active = 1'b1;
            timeout_evt = 1'b1;
         end
      end

      if (next_st.count > st.peak_count)
      begin
         next_st.peak_count = next_st.count;
      end

      // register writes
      if (reg_wr)
      begin
         if (reg_addr == `IOWD_REG_IRQ_ENABLE)
         begin
            next_st.irq_enable = reg_wdata[`IOWD_LINES-1:0] & ~FLAG_RESERVED;
         end
         else if (reg_addr == `IOWD_REG_PERIOD)
         begin
            next_st.watchdog_period = reg_wdata[31:0];
            next_st.count = '0;
            next_st.presc = '0;
            next_st.peak_count = '0;
            next_st.timeout_active = 1'b0;
            timeout_evt = 1'b0;
         end
         else if (reg_addr == `IOWD_REG_CONFIG)
         begin
            next_st.sticky_timeout = reg_wdata[`IOWD_CFG_STICKY];
            next_st.host_en = reg_wdata[`IOWD_CFG_HOST_EN];
            next_st.ctrl_en = reg_wdata[`IOWD_CFG_CTRL_EN];
            next_st.sof_en = reg_wdata[`IOWD_CFG_SOF_EN];
            next_st.in_edge = reg_wdata[`IOWD_CFG_IN_EDGE];
         end
         else if (reg_addr == `IOWD_REG_OUT_LEVELS)
         begin
            next_st.output_safe_level = reg_wdata[`IOWD_LEVEL_LSB +: `IOWD_LINES];
            next_st.output_override_select = reg_wdata[`IOWD_SELECT_LSB +: `IOWD_LINES];
         end
         else if (reg_addr == `IOWD_REG_OE_LEVELS)
         begin
            next_st.output_enable_safe_levels = reg_wdata[`IOWD_OE_W-1:0];
         end
         else if (reg_addr == `IOWD_REG_IN_LEVELS)
         begin
            next_st.input_retrigger_level = reg_wdata[`IOWD_LEVEL_LSB +: `IOWD_LINES];
            next_st.input_retrigger_select = reg_wdata[`IOWD_SELECT_LSB +: `IOWD_LINES];
         end
      end

      // register reads; unmapped numbers read zero
      if (reg_rd)
      begin
         if (reg_addr == `IOWD_REG_IRQ_ENABLE)
         begin
            next_st.rdata = {40'h0000000000, st.irq_enable};
         end
         else if (reg_addr == `IOWD_REG_EVENT_FLAGS)
         begin
            next_st.rdata = {40'h0000000000, st.event_flags & ~FLAG_RESERVED};
            flags_read = 1'b1;
         end
         else if (reg_addr == `IOWD_REG_PERIOD)
         begin
            next_st.rdata = {32'h00000000, st.watchdog_period};
         end
         else if (reg_addr == `IOWD_REG_CONFIG)
         begin
            next_st.rdata = {56'h00000000000000, st.timeout_active, 2'b00, st.in_edge,
                             st.sof_en, st.ctrl_en, st.host_en, st.sticky_timeout};
         end
         else if (reg_addr == `IOWD_REG_OUT_LEVELS)
         begin
            next_st.rdata = {8'h00, st.output_override_select, 8'h00, st.output_safe_level};
         end
         else if (reg_addr == `IOWD_REG_OE_LEVELS)
         begin
            next_st.rdata = {32'h00000000, st.output_enable_safe_levels};
         end
         else if (reg_addr == `IOWD_REG_IN_LEVELS)
         begin
            next_st.rdata = {8'h00, st.input_retrigger_select, 8'h00, st.input_retrigger_level};
         end
         else if (reg_addr == `IOWD_REG_PEAK)
         begin
            next_st.rdata = {32'h00000000, st.peak_count};
         end
         else
         begin
            next_st.rdata = `IOWD_RESET_WORD;
         end
      end

      // a flag raised in the cycle of its clearing read survives it
      flag_set = event_in & ~FLAG_RESERVED;
      flag_set[`IOWD_FLAG_TIMEOUT] = timeout_evt;
      if (flags_read)
      begin
         next_st.event_flags = flag_set;
      end
      else
      begin
         next_st.event_flags = st.event_flags | flag_set;
      end

      next_st.irq = |(st.event_flags & st.irq_enable);
      next_st.io_out = ovr_out;
      next_st.io_oe = ovr_oe;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st <= '0;
      end
      else if (clk_en)
      begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rdata;
   assign io_out = st.io_out;
   assign io_oe = st.io_oe;
   assign timeout_active = st.timeout_active;
   assign combined_irq_out = st.irq;

endmodule

`default_nettype wire

/* File: iowd_cfg.svh */
/*
   constants of the i/o watchdog: register numbers, field positions,
   reset values and clock rates.
   assumes it is included by bare name from the package and the modules.
*/
`ifndef IOWD_CFG_SVH
`define IOWD_CFG_SVH

// register numbers on the register port
`define IOWD_REG_IRQ_ENABLE 8'h33
`define IOWD_REG_EVENT_FLAGS 8'h34
`define IOWD_REG_PERIOD 8'h35
`define IOWD_REG_CONFIG 8'h36
`define IOWD_REG_OUT_LEVELS 8'h37
`define IOWD_REG_OE_LEVELS 8'h38
`define IOWD_REG_IN_LEVELS 8'h39
`define IOWD_REG_PEAK 8'h3a

// watchdog_config fields
`define IOWD_CFG_STICKY 0
`define IOWD_CFG_HOST_EN 1
`define IOWD_CFG_CTRL_EN 2
`define IOWD_CFG_SOF_EN 3
`define IOWD_CFG_IN_EDGE 4
`define IOWD_CFG_ACTIVE 7

// 64-bit level registers: level field low, select field high
`define IOWD_LEVEL_LSB 0
`define IOWD_SELECT_LSB 32

// event_flags fields
`define IOWD_FLAG_TIMEOUT 11
`define IOWD_FLAG_RESERVED 24'h700000

// reset values
`define IOWD_RESET_WORD 64'h0000000000000000

// timing: system clock and watchdog count rate
`define IOWD_CLK_MHZ 250
`define IOWD_WD_MHZ 25
`define IOWD_TICK_DIV (`IOWD_CLK_MHZ / `IOWD_WD_MHZ)
`define IOWD_PRESC_W 4

// widths
`define IOWD_LINES 24
`define IOWD_OE_W 32
`define IOWD_SYNC_W 27

`endif

/* File: iowd_pkg.sv */
/*
   types of the i/o watchdog: state records of the top and the
   synchroniser.
   assumes iowd_cfg.svh is on the include path.
*/
`include "iowd_cfg.svh"

package iowd_pkg;

   typedef struct packed {
      logic [`IOWD_SYNC_W-1:0] s1;
      logic [`IOWD_SYNC_W-1:0] s2;
      logic [`IOWD_SYNC_W-1:0] s3;
   } iowd_sync_t;

   typedef struct packed {
      logic [`IOWD_LINES-1:0] irq_enable;
      logic [`IOWD_LINES-1:0] event_flags;
      logic [31:0] watchdog_period;
      logic sticky_timeout;
      logic host_en;
      logic ctrl_en;
      logic sof_en;
      logic in_edge;
      logic timeout_active;
      logic [`IOWD_LINES-1:0] output_safe_level;
      logic [`IOWD_LINES-1:0] output_override_select;
      logic [`IOWD_OE_W-1:0] output_enable_safe_levels;
      logic [`IOWD_LINES-1:0] input_retrigger_level;
      logic [`IOWD_LINES-1:0] input_retrigger_select;
      logic [31:0] count;
      logic [31:0] peak_count;
      logic [`IOWD_PRESC_W-1:0] presc;
      logic [`IOWD_LINES-1:0] cond_prev;
      logic [`IOWD_LINES-1:0] io_out;
      logic [`IOWD_OE_W-1:0] io_oe;
      logic [63:0] rdata;
      logic irq;
   } iowd_state_t;

endpackage

/* File: iowd_sync_edge.sv */
/*
   two-stage synchroniser with a third stage for edge detection,
   one bit per retrigger source.
   assumes sources are plain levels; edges are flagged for one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "iowd_cfg.svh"

module iowd_sync_edge
   import iowd_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   // raw sources
   input wire logic [`IOWD_SYNC_W-1:0] raw,
   // synchronised level and edges
   output logic [`IOWD_SYNC_W-1:0] level,
   output logic [`IOWD_SYNC_W-1:0] rise,
   output logic [`IOWD_SYNC_W-1:0] fall
);

   // selects idle high; resetting them low would fake a rising edge after reset
   localparam logic [`IOWD_SYNC_W-1:0] IDLE_LEVEL = 27'h6000000;

   iowd_sync_t st;
   iowd_sync_t next_st;

   always_comb
   begin
      next_st = st;
      next_st.s1 = raw;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st <= {IDLE_LEVEL, IDLE_LEVEL, IDLE_LEVEL};
      end
      else if (clk_en)
      begin
         st <= next_st;
      end
   end

   // s1 feeds s2 only; edges compare the later stages
   assign level = st.s2;
   assign rise = st.s2 & ~st.s3;
   assign fall = ~st.s2 & st.s3;

endmodule

`default_nettype wire

/* File: iowd_top_properties.sv */
/*
   port checker of the i/o watchdog, with shadows of written registers.
   assumes clk_en stays high and registers start at zero.
*/
`timescale 1ns/1ps
`default_nettype none
`include "iowd_cfg.svh"

module iowd_top_properties
   import iowd_pkg::*;
#(
   parameter int TICK_DIV = 2
)
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [63:0] reg_wdata,
   input wire logic [63:0] reg_rdata,
   // pins
   input wire logic [23:0] app_out,
   input wire logic [23:0] io_out,
   input wire logic [31:0] io_oe,
   input wire logic timeout_active,
   input wire logic combined_irq_out
);
   logic [63:0] lv, oe, en, per;
   logic [31:0] cyc;
   logic [23:0] exp_io, oe_exp;

   always_comb
   begin
      exp_io = timeout_active ? ((app_out & ~lv[55:32]) | (lv[23:0] & lv[55:32])) : app_out;
      oe_exp = oe[23:0] & lv[55:32];
   end

   // cycles since the last period write bound how early a timeout may come
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lv <= '0;
         oe <= '0;
         en <= '0;
         per <= '0;
         cyc <= '0;
      end
      else
      begin
         cyc <= (reg_wr && reg_addr == `IOWD_REG_PERIOD) ? '0 : cyc + 32'h1;
         if (reg_wr && reg_addr == `IOWD_REG_OUT_LEVELS)
            lv <= reg_wdata;
         if (reg_wr && reg_addr == `IOWD_REG_OE_LEVELS)
            oe <= reg_wdata;
         if (reg_wr && reg_addr == `IOWD_REG_IRQ_ENABLE)
            en <= reg_wdata;
         if (reg_wr && reg_addr == `IOWD_REG_PERIOD)
            per <= reg_wdata;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   a_io_follow: assert property ($past(rst_n) |-> io_out == $past(exp_io))
      else $error("io_out differs from app_out or safe level");
   a_oe_safe: assert property ($past(timeout_active) |-> (io_oe[23:0] & $past(lv[55:32])) == $past(oe_exp))
      else $error("io_oe of overridden line wrong");
   a_rdata_holds: assert property ($past(rst_n) && !$past(reg_rd) |-> $stable(reg_rdata))
      else $error("read data moved without a read");
   a_flags_reserved: assert property ($past(reg_rd) && $past(reg_addr) == `IOWD_REG_EVENT_FLAGS |-> reg_rdata[63:24] == '0 && reg_rdata[22:20] == '0)
      else $error("reserved flag bits not zero");
   a_write_clears: assert property (reg_wr && reg_addr == `IOWD_REG_PERIOD |=> !timeout_active)
      else $error("period write left timeout active");
   a_zero_off: assert property (per == '0 |=> !timeout_active)
      else $error("timeout with zero period");
   a_not_early: assert property ($rose(timeout_active) |-> cyc >= TICK_DIV * per)
      else $error("timeout before the period elapsed");
   a_irq_follows: assert property ($rose(timeout_active) && en[11] |=> combined_irq_out)
      else $error("enabled timeout flag gave no interrupt");

   c_timeout: cover property ($rose(timeout_active));
   c_release: cover property ($fell(timeout_active) && !$past(reg_wr));
   c_flag_read: cover property (reg_rd && reg_addr == `IOWD_REG_EVENT_FLAGS);
endmodule
`default_nettype wire

/* File: iowd_reg_master.sv */
/*
   register master: fieldbus side or local host on the register port.
   assumes one bench process calls its tasks; drives on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none

module iowd_reg_master
(
   // clock
   input wire logic clock,
   // register port
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [63:0] reg_wdata,
   input wire logic [63:0] reg_rdata
);
   initial
   begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 64'h0;
   end

   // idle bus shows inverted junk, never the last request
   task automatic put(input logic w, input logic [7:0] a, input logic [63:0] d);
      @(negedge clock);
      reg_wr = w;
      reg_rd = !w;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clock);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [63:0] d);
      put(1'b0, a, 64'h0);
      d = reg_rdata;
   endtask
endmodule
`default_nettype wire

/* File: tb_iowd_top.sv */
/*
   self-checking bench of the i/o watchdog.
   assumes the design, its checker and the register master compile first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_iowd_top;
   localparam int TICK = 2;
   typedef struct { logic [7:0] a; logic [63:0] d; logic [63:0] x; } iowd_row_t;
   logic clock, rst_n, host_n, ctrl_n, sof, reg_wr, reg_rd, active, irq;
   logic [23:0] io_in, app_out, event_in, io_out;
   logic [31:0] app_oe, io_oe;
   logic [7:0] reg_addr;
   logic [63:0] reg_wdata, reg_rdata, got;
   int num_errors = 0;
   int num_checks = 0;
   logic [7:0] cfgs [5] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h00};
   iowd_row_t rows [8] = '{'{8'h33, '1, 64'h8fffff}, '{8'h37, '1, 64'hffffff00ffffff},
      '{8'h38, '1, 64'hffffffff}, '{8'h39, 64'h100000001, 64'h100000001},
      '{8'h36, '1, 64'h1f}, '{8'h34, '1, 64'h0}, '{8'h3b, '1, 64'h0},
      '{8'h35, 64'h12345678, 64'h12345678}};

   iowd_reg_master iowd_reg_master_inst (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   iowd_top #(.TICK_DIV(TICK)) iowd_top_inst (.clock(clock), .rst_n(rst_n), .clk_en(1'b1),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .host_port_select_n(host_n), .ctrl_port_select_n(ctrl_n),
      .frame_start(sof), .io_in(io_in), .app_out(app_out), .app_oe(app_oe),
      .event_in(event_in), .io_out(io_out), .io_oe(io_oe), .timeout_active(active),
      .combined_irq_out(irq));

   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task automatic check(input string n, input logic [63:0] s, input logic [63:0] e);
      num_checks++;
      if (s !== e)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [63:0] d);
      iowd_reg_master_inst.put(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      iowd_reg_master_inst.rd(a, got);
   endtask

   // bounded wait; running out ends the run
   task automatic wait_act(input logic v);
      for (int i = 0; i < 400 && active !== v; i++)
         @(negedge clock);
      if (active !== v)
      begin
         num_errors++;
         close_out();
      end
   endtask

   // selects pulse low, frame start high, input line 0 moves and stays
   task automatic kick(input int k);
      @(negedge clock);
      case (k)
         0: host_n = 1'b0;
         1: ctrl_n = 1'b0;
         2: sof = 1'b1;
         default: io_in[0] = (k == 3);
      endcase
      repeat (4) @(negedge clock);
      host_n = 1'b1;
      ctrl_n = 1'b1;
      sof = 1'b0;
   endtask

   initial
   begin
      rst_n = 1'b0;
      host_n = 1'b1;
      ctrl_n = 1'b1;
      sof = 1'b0;
      io_in = '0;
      app_out = '0;
      app_oe = '0;
      event_in = '0;
      repeat (10) @(negedge clock);
      check("reset pins", {io_out, io_oe, active, irq}, '0);
      rst_n = 1'b1;
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a);
         check("readback", got, rows[i].x);
      end
      rd(8'h3a);
      check("peak running", got != '0, 64'h1);
      app_out = 24'hf0f0f0;
      wr(8'h37, 64'hf00000005);
      wr(8'h38, 64'ha);
      wr(8'h33, 64'h800);
      wr(8'h36, 64'h02);
      wr(8'h35, 64'h3);
      wait_act(1'b1);
      repeat (2) @(negedge clock);
      check("io_out", io_out, 24'hf0f0f5);
      check("io_oe", io_oe & 32'hf, 32'ha);
      check("irq", irq, 1'b1);
      rd(8'h36);
      check("config", got, 64'h82);
      rd(8'h3a);
      check("peak", got, 64'h3);
      event_in = 24'h700001;
      @(negedge clock);
      event_in = '0;
      rd(8'h34);
      check("flags", got, 64'h801);
      rd(8'h34);
      check("flags again", got, 64'h0);
      repeat (2) @(negedge clock);
      check("irq cleared", irq, 1'b0);
      kick(0);
      wait_act(1'b0);
      repeat (2) @(negedge clock);
      check("io_out released", io_out, 24'hf0f0f0);
      // sticky mode: a retrigger alone must not release
      wr(8'h36, 64'h03);
      wr(8'h35, 64'h3);
      wait_act(1'b1);
      kick(0);
      repeat (4) @(negedge clock);
      check("sticky", active, 1'b1);
      wr(8'h35, 64'h3);
      check("rewrite", active, 1'b0);
      wr(8'h35, 64'h0);
      repeat (40) @(negedge clock);
      check("disabled", active, 1'b0);
      rd(8'h3a);
      check("peak cleared", got, 64'h0);
      foreach (cfgs[k])
      begin
         wr(8'h36, {56'h0, cfgs[k]});
         wr(8'h35, 64'h3);
         wait_act(1'b1);
         kick(k);
         wait_act(1'b0);
         check("retrigger", active, 1'b0);
      end
      close_out();
   end
endmodule

bind iowd_top iowd_top_properties #(.TICK_DIV(TICK_DIV)) iowd_top_properties_inst (
   .clock(clock), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .app_out(app_out), .io_out(io_out),
   .io_oe(io_oe), .timeout_active(timeout_active), .combined_irq_out(combined_irq_out));
`default_nettype wire
